// >>> rtl/lmrs_pkg.sv
// package for the led matrix row refresh scanner: map, fields, timing
package lmrs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_COLS = 20;
    localparam int NUM_ROWS = 8;
    localparam int CNT_W = 9;
    localparam int POS_W = 6;
    localparam int ROW_W = 3;
    localparam int PRE_W = 3;
    // register byte offsets; dot rows occupy 0x00..0x1c, one word per row
    localparam logic [7:0] DOT_BASE = 8'h00;
    localparam logic [7:0] CTRL0_OFF = 8'h20;
    localparam logic [7:0] CTRL1_OFF = 8'h24;
    localparam logic [7:0] STAT_OFF = 8'h28;
    // control word 0 fields
    localparam int ONT_LSB = 0;
    localparam int PEAK_LSB = 4;
    localparam int SLEEP_BIT = 6;
    localparam logic [6:0] CTRL0_RST = 7'h00;
    // control word 1 fields
    localparam int PRESC_BIT = 0;
    localparam int EXTSEL_BIT = 1;
    localparam logic [1:0] CTRL1_RST = 2'h0;
    // scan timing in display clock cycles
    localparam logic [POS_W-1:0] SLOT_LAST = 6'h3f;
    localparam logic [POS_W-1:0] MAX_ON = 6'h3c;
    localparam logic [CNT_W-1:0] SCAN_LAST = 9'h1ff;
    localparam logic [PRE_W-1:0] PRE_LAST = 3'h7;
    // internal oscillator period in ns and its length in ref_clk cycles
    localparam int REF_PERIOD_NS = 5;
    localparam int INT_OSC_PERIOD_NS = 4000;
    localparam int INT_DIV = INT_OSC_PERIOD_NS / REF_PERIOD_NS;
    localparam int DIV_W = 10;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lmrs_bus_req_t;

    typedef struct packed {
        logic sleep_n;
        logic [1:0] peak;
        logic [3:0] ontime;
    } lmrs_ctrl0_t;
endpackage

// >>> rtl/lmrs_scanner.sv
// led matrix row refresh scanner with register port and scan outputs
// Operation
// [RULE1] dot store is 20 columns by 8 rows
// [RULE2] one-of-eight row select, single row active
// [RULE3] full scan is 512 display clocks
// [RULE4] each row slot lasts 64 display clocks
// [RULE5] last 4 cycles of slot stay dark
// [RULE6] lit cycles per row follow on-time code
// [RULE7] at most 20 leds on at once
// [RULE8] peak in bits 5:4, on-time in 3:0
// [RULE9] display clock from internal or external oscillator
// [RULE10] external oscillator runs at 51.2 kHz or faster
// [RULE11] prescale bit divides external oscillator by 8
// [RULE12] sleep low stops oscillator, display dark
// [RULE13] nine-bit counter: row upper, position lower
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module lmrs_scanner (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire lmrs_pkg::lmrs_bus_req_t bus_req,
    output logic [lmrs_pkg::DATA_W-1:0] rdata,
    // external oscillator, synchronous to ref_clk
    input wire logic ext_osc,
    // matrix drive
    output logic [lmrs_pkg::NUM_COLS-1:0] col_on,
    output logic [lmrs_pkg::NUM_ROWS-1:0] row_on,
    output logic [1:0] peak_cur
);
    import lmrs_pkg::*;

    // on-cycles per row slot for each on-time code; code 4'hd gives 36 (60%)
    function automatic logic [POS_W-1:0] on_cycles(input logic [3:0] code);
        case (code)
            4'h0: on_cycles = 6'h00;
            4'h1: on_cycles = 6'h01;
            4'h2: on_cycles = 6'h02;
            4'h3: on_cycles = 6'h03;
            4'h4: on_cycles = 6'h04;
            4'h5: on_cycles = 6'h06;
            4'h6: on_cycles = 6'h08;
            4'h7: on_cycles = 6'h0a;
            4'h8: on_cycles = 6'h0c;
            4'h9: on_cycles = 6'h0e;
            4'ha: on_cycles = 6'h12;
            4'hb: on_cycles = 6'h16;
            4'hc: on_cycles = 6'h1c;
            4'hd: on_cycles = 6'h24;
            4'he: on_cycles = 6'h30;
            default: on_cycles = 6'h3c;
        endcase
    endfunction

    logic [NUM_COLS-1:0] dots_reg [NUM_ROWS];
    lmrs_ctrl0_t ctrl0_reg;
    logic [1:0] ctrl1_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [DIV_W-1:0] div_reg;
    logic [PRE_W-1:0] pre_reg;
    logic ext_d_reg;
    logic [NUM_COLS-1:0] col_reg;
    logic [NUM_ROWS-1:0] row_reg;

    // register decode
    wire is_dot = bus_req.addr[7:5] == DOT_BASE[7:5] && bus_req.addr[1:0] == 2'h0;
    wire [ROW_W-1:0] dot_idx = bus_req.addr[4:2];
    wire wr_ctrl0 = bus_req.wr && bus_req.addr == CTRL0_OFF;
    wire wr_ctrl1 = bus_req.wr && bus_req.addr == CTRL1_OFF;
    wire prescale = ctrl1_reg[PRESC_BIT];
    wire ext_sel = ctrl1_reg[EXTSEL_BIT];
    wire awake = ctrl0_reg.sleep_n;

    // scan position split out of the refresh counter
    wire [ROW_W-1:0] row_idx = cnt_reg[CNT_W-1:POS_W]; // see [RULE13]
    wire [POS_W-1:0] pos = cnt_reg[POS_W-1:0]; // see [RULE13]
    wire [NUM_COLS-1:0] cur_dots = dots_reg[row_idx]; // see [RULE1]

    // display clock sources; internal divider halts in sleep
    wire int_tick = awake && div_reg == DIV_W'(INT_DIV - 1); // see [RULE12]
    wire ext_rise = ext_osc && !ext_d_reg;
    wire ext_tick = ext_rise && (!prescale || pre_reg == PRE_LAST); // see [RULE11]
    wire disp_tick = ext_sel ? ext_tick : int_tick; // see [RULE9]

    // pixels lit only inside on-time and never in the 4-cycle blank tail
    wire [POS_W-1:0] on_len = on_cycles(ctrl0_reg.ontime); // see [RULE6]
    wire lit = awake && pos < on_len && pos < MAX_ON; // see [RULE5]

    wire [DATA_W-1:0] rd_mux =
        is_dot ? DATA_W'(dots_reg[dot_idx]) :
        bus_req.addr == CTRL0_OFF ? DATA_W'(ctrl0_reg) :
        bus_req.addr == CTRL1_OFF ? DATA_W'(ctrl1_reg) :
        bus_req.addr == STAT_OFF ? DATA_W'({lit, cnt_reg}) :
        '0;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_ROWS; i++) begin
                dots_reg[i] <= '0;
            end
        end else if (bus_req.wr && is_dot) begin
            dots_reg[dot_idx] <= bus_req.wdata[NUM_COLS-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl0_reg <= CTRL0_RST;
            ctrl1_reg <= CTRL1_RST;
            rdata_reg <= '0;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_reg <= bus_req.wdata[6:0]; // see [RULE8]
            end
            if (wr_ctrl1) begin
                ctrl1_reg <= bus_req.wdata[1:0];
            end
            rdata_reg <= bus_req.rd ? rd_mux : '0;
        end
    end

    // oscillator divider, external edge detect and prescaler
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
            ext_d_reg <= 1'b0;
            pre_reg <= '0;
        end else begin
            div_reg <= (!awake || int_tick) ? '0 : div_reg + 1'b1;
            ext_d_reg <= ext_osc;
            if (ext_rise) begin
                pre_reg <= pre_reg + 1'b1; // see [RULE11]
            end
        end
    end

    // free-running refresh counter; wraps after 512 display clocks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (disp_tick) begin
            cnt_reg <= cnt_reg + 1'b1; // see [RULE3]
        end
    end

    // drive stage: only the active row's pixels reach the column sources
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            col_reg <= '0;
            row_reg <= '0;
        end else begin
            col_reg <= lit ? cur_dots : '0; // see [RULE7]
            row_reg <= awake ? NUM_ROWS'(1) << row_idx : '0; // see [RULE2]
        end
    end

    assign rdata = rdata_reg;
    assign col_on = col_reg;
    assign row_on = row_reg;
    assign peak_cur = ctrl0_reg.peak; // see [RULE8]

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_row_onehot: assert property ($onehot0(row_reg)) // see [RULE2]
        else $error("more than one row sink active");
    a_scan_wrap: assert property (disp_tick && cnt_reg == SCAN_LAST |=> cnt_reg == '0) // see [RULE3]
        else $error("scan did not wrap after 512 cycles");
    a_slot_advance: assert property (disp_tick && pos == SLOT_LAST |=> // see [RULE4]
        row_idx == $past(row_idx) + 3'h1 && pos == '0)
        else $error("row slot did not advance after 64 cycles");
    a_blank_tail: assert property (pos >= MAX_ON |=> col_reg == '0) // see [RULE5]
        else $error("pixels lit in blank tail of slot");
    a_on_time: assert property (awake && pos < on_cycles(ctrl0_reg.ontime) // see [RULE6]
        |=> col_reg == $past(cur_dots))
        else $error("row not driven during on-time");
    a_off_time: assert property (pos >= on_cycles(ctrl0_reg.ontime) |=> col_reg == '0) // see [RULE6]
        else $error("row driven after on-time");
    a_col_subset: assert property (##1 (col_reg & ~$past(cur_dots)) == '0) // see [RULE7]
        else $error("column driven without dot set in active row");
    a_peak_write: assert property (wr_ctrl0 |=> peak_cur == $past(bus_req.wdata[5:4])) // see [RULE8]
        else $error("peak current field not taken from bits 5:4");
    a_prescale_hold: assert property (ext_sel && prescale && ext_rise && // see [RULE11]
        pre_reg != PRE_LAST |=> $stable(cnt_reg))
        else $error("prescaled clock advanced scan early");
    a_sleep_dark: assert property (!awake |=> col_reg == '0 && row_reg == '0) // see [RULE12]
        else $error("display not dark in sleep");
    a_int_stopped: assert property (!ext_sel && !awake |=> $stable(cnt_reg)) // see [RULE9]
        else $error("internal oscillator ran in sleep");

    c_scan_wrap: cover property (disp_tick && cnt_reg == SCAN_LAST);
    c_last_row_lit: cover property (row_idx == 3'h7 && col_reg != '0);
    c_prescaled_tick: cover property (ext_sel && prescale && ext_tick);
    c_full_on: cover property (lit && pos == MAX_ON - 6'h1);
    c_sleep_entry: cover property (wr_ctrl0 && !bus_req.wdata[SLEEP_BIT]);

    // register port behaviour
    a_dot_write: assert property (bus_req.wr && is_dot |=> // see [RULE1]
        dots_reg[$past(dot_idx)] == $past(bus_req.wdata[NUM_COLS-1:0]))
        else $error("dot row write did not land");
    a_dot_read: assert property (bus_req.rd && is_dot |=> // see [RULE1]
        rdata == DATA_W'($past(dots_reg[dot_idx])))
        else $error("dot row read returned wrong data");
    a_rdata_idle: assert property (!bus_req.rd |=> rdata == '0) // see [RULE1]
        else $error("read data not zero outside read answer");
    a_ctrl0_read: assert property (bus_req.rd && bus_req.addr == CTRL0_OFF |=> // see [RULE8]
        rdata == DATA_W'($past(ctrl0_reg)))
        else $error("control word 0 read returned wrong data");
    a_ontime_write: assert property (wr_ctrl0 |=> // see [RULE8]
        ctrl0_reg.ontime == $past(bus_req.wdata[3:0]))
        else $error("on-time field not taken from bits 3:0");
    a_peak_hold: assert property (!wr_ctrl0 |=> $stable(peak_cur)) // see [RULE8]
        else $error("peak current changed without a write");
    a_sleep_write: assert property (wr_ctrl0 |=> // see [RULE12]
        awake == $past(bus_req.wdata[SLEEP_BIT]))
        else $error("sleep bit not taken from bit 6");
    a_ctrl1_write: assert property (wr_ctrl1 |=> // see [RULE9]
        ext_sel == $past(bus_req.wdata[EXTSEL_BIT]) &&
        prescale == $past(bus_req.wdata[PRESC_BIT]))
        else $error("control word 1 write did not land");

    // row selection
    a_row_follows: assert property (awake |=> // see [RULE2]
        row_reg == NUM_ROWS'(1) << $past(row_idx))
        else $error("row sink does not follow row index");
    a_row_present: assert property (awake |=> row_reg != '0) // see [RULE2]
        else $error("no row sink active while awake");
    a_col_rowless: assert property (row_reg == '0 |-> col_reg == '0) // see [RULE7]
        else $error("columns driven with no row active");

    // refresh counter
    a_cnt_step: assert property (disp_tick |=> cnt_reg == $past(cnt_reg) + 9'h001) // see [RULE3]
        else $error("refresh counter did not step on tick");
    a_cnt_hold: assert property (!disp_tick |=> $stable(cnt_reg)) // see [RULE13]
        else $error("refresh counter moved without tick");
    a_slot_hold: assert property (disp_tick && pos != SLOT_LAST |=> // see [RULE4]
        row_idx == $past(row_idx))
        else $error("row changed inside its slot");

    // lit window
    a_lit_range: assert property (lit |-> pos < MAX_ON) // see [RULE5]
        else $error("lit flag set in blank tail");
    a_lit_len: assert property (lit |-> pos < on_len) // see [RULE6]
        else $error("lit flag set past on-time");
    a_lit_exact: assert property (awake && pos < on_len |-> lit) // see [RULE6]
        else $error("lit flag missing inside on-time");

    // clock sources
    a_src_ext: assert property (ext_sel |-> disp_tick == ext_tick) // see [RULE9]
        else $error("external source not pacing the scan");
    a_src_int: assert property (!ext_sel |-> disp_tick == int_tick) // see [RULE9]
        else $error("internal source not pacing the scan");
    a_div_step: assert property (awake && !int_tick |=> // see [RULE9]
        div_reg == $past(div_reg) + 10'h001)
        else $error("internal divider did not count");
    a_div_sleep: assert property (!awake |=> div_reg == '0) // see [RULE12]
        else $error("internal divider ran in sleep");
    a_direct_ext: assert property (ext_sel && !prescale |-> disp_tick == ext_rise) // see [RULE11]
        else $error("unscaled external edge not used directly");
    a_prescale_tick: assert property (ext_sel && prescale && ext_rise && // see [RULE11]
        pre_reg == PRE_LAST |-> disp_tick)
        else $error("eighth external edge gave no tick");
    a_pre_count: assert property (ext_rise |=> pre_reg == $past(pre_reg) + 3'h1) // see [RULE11]
        else $error("prescaler missed an external edge");

    // lit display ticks per slot; a control write inside a slot spoils that slot's count,
    // so the check waits for the next clean slot
    logic [POS_W:0] lit_ticks_reg;
    logic slot_dirty_reg;
    wire slot_end = disp_tick && pos == SLOT_LAST;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lit_ticks_reg <= '0;
            slot_dirty_reg <= 1'b1;
        end else if (slot_end) begin
            lit_ticks_reg <= '0;
            slot_dirty_reg <= wr_ctrl0 || wr_ctrl1;
        end else begin
            if (disp_tick && lit) begin
                lit_ticks_reg <= lit_ticks_reg + 1'b1;
            end
            if (wr_ctrl0 || wr_ctrl1) begin
                slot_dirty_reg <= 1'b1;
            end
        end
    end
    a_slot_lit: assert property (slot_end && awake && !slot_dirty_reg |-> // see [RULE6]
        lit_ticks_reg == {1'b0, on_len})
        else $error("lit ticks in slot differ from on-time");
endmodule

// >>> test/lmrs_matrix_model.sv
// led matrix model: decodes the active row and counts lit pixels
`timescale 1ns/10ps
module lmrs_matrix_model (
    // matrix lines from the scanner
    input wire logic [lmrs_pkg::NUM_COLS-1:0] col_on,
    input wire logic [lmrs_pkg::NUM_ROWS-1:0] row_on,
    // observed state
    output logic multi_row,
    output logic [2:0] row_idx,
    output logic [4:0] lit_leds
);
    import lmrs_pkg::*;
    // a pixel only lights where a row sink and a column source are both on
    always_comb begin
        multi_row = !$onehot0(row_on);
        row_idx = 3'h0;
        lit_leds = 5'h00;
        for (int r = 0; r < NUM_ROWS; r++) begin
            if (row_on[r]) begin
                row_idx = 3'(r);
            end
        end
        for (int c = 0; c < NUM_COLS; c++) begin
            lit_leds = lit_leds + 5'(col_on[c] & (row_on != 8'h00));
        end
    end
endmodule

// >>> test/testbench.sv
// self-checking bench for the scanner: registers, scan timing, clock sources
`timescale 1ns/10ps
module testbench;
    import lmrs_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ext_osc = 1'b0;
    logic ext_run = 1'b0;
    lmrs_bus_req_t req = '0;
    logic [DATA_W-1:0] rdata;
    logic [NUM_COLS-1:0] col_on;
    logic [NUM_ROWS-1:0] row_on;
    logic [1:0] peak_cur;
    logic multi_row;
    logic [2:0] row_idx;
    logic [4:0] lit_leds;
    logic [NUM_COLS-1:0] dots [NUM_ROWS];
    logic [31:0] seed = 32'h931c;
    int errors = 0;
    int n_tests = 0;

    always #2.5 ref_clk = ~ref_clk;
    // one rising edge every two clocks keeps a full scan at 1024 clocks
    always @(posedge ref_clk) ext_osc <= ext_run & ~ext_osc;

    lmrs_scanner u_lmrs_scanner (.ref_clk(ref_clk), .rst(rst), .bus_req(req), .rdata(rdata),
        .ext_osc(ext_osc), .col_on(col_on), .row_on(row_on), .peak_cur(peak_cur));
    lmrs_matrix_model u_lmrs_matrix_model (.col_on(col_on), .row_on(row_on),
        .multi_row(multi_row), .row_idx(row_idx), .lit_leds(lit_leds));

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic int on_cycles(input int code);
        int t [16] = '{0, 1, 2, 3, 4, 6, 8, 10, 12, 14, 18, 22, 28, 36, 48, 60};
        return t[code];
    endfunction
    task automatic conclude();
        if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic err(input string m);
        errors++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_tests++;
        if (g !== e) err(m);
    endtask
    // one idle cycle after each strobe so no signal is assigned twice per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge ref_clk);
        req <= '0;
        #1 d = rdata;
        @(posedge ref_clk);
    endtask
    task automatic scan(input int n, output int row0, output int lit);
        row0 = 0;
        lit = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            if (row_on === 8'h01) row0++;
            if (col_on !== 20'h0) lit++;
            if (col_on !== 20'h0 && (col_on !== dots[row_idx] || multi_row !== 1'b0))
                err("columns lit off the active row");
            if (lit_leds > 5'h14)
                err("too many leds lit at once");
        end
        @(posedge ref_clk);
    endtask
    // 3200 clocks apart, the counter must advance by exactly e: four internal ticks awake, none in sleep
    task automatic step4(input logic [8:0] e, input string m);
        logic [31:0] s0;
        logic [31:0] s1;
        rd(STAT_OFF, s0);
        repeat (3198) @(posedge ref_clk);
        rd(STAT_OFF, s1);
        chk(32'(9'(s1[8:0] - s0[8:0])), 32'(e), m);
    endtask

    initial begin
        #300000;
        err("watchdog expired");
        conclude();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] pk;
        int row0;
        int lit;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(CTRL0_OFF, d);
        chk(d, 32'h0, "ctrl0 reset value");
        chk({row_on, col_on}, 28'h0, "display lit after reset");
        for (int r = 0; r < NUM_ROWS; r++) begin
            d = rnd();
            dots[r] = d[19:0] | 20'h1;
            wr(8'(4 * r), {d[31:20], dots[r]});
            rd(8'(4 * r), d);
            chk(d, {12'h0, dots[r]}, "dot row readback");
        end
        rd(8'h3c, d);
        chk(d, 32'h0, "unmapped read");
        wr(CTRL1_OFF, 32'h2);
        ext_run <= 1'b1;
        for (int code = 0; code < 16; code++) begin
            pk = 2'(rnd());
            wr(CTRL0_OFF, {25'h0, 1'b1, pk, 4'(code)});
            chk(32'(peak_cur), 32'(pk), "peak current field");
            scan(1024, row0, lit);
            chk(row0, 128, "row slot length");
            chk(lit, 16 * on_cycles(code), "lit cycles per scan");
        end
        wr(CTRL1_OFF, 32'h3);
        scan(8192, row0, lit);
        chk(row0, 1024, "prescaled row slot");
        chk(lit, 7680, "dark tail of each slot");
        ext_run <= 1'b0;
        wr(CTRL1_OFF, 32'h0);
        step4(9'h004, "internal oscillator rate");
        wr(CTRL0_OFF, 32'h0);
        step4(9'h000, "counter runs in sleep");
        chk({row_on, col_on}, 28'h0, "display lit in sleep");
        conclude();
    end
endmodule
